// ==== verilog/tmr_pkg.sv ====
// Package with register offsets, field positions and reset values of the sixteen-bit counter.
package tmr_pkg;
  // Word-aligned byte addresses on the Avalon-MM register bus.
  localparam logic [4:0] TMR_OFS_LOW      = 5'h00;
  localparam logic [4:0] TMR_OFS_HIGH     = 5'h04;
  localparam logic [4:0] TMR_OFS_CTRL     = 5'h08;
  localparam logic [4:0] TMR_OFS_COMP     = 5'h0C;
  localparam logic [4:0] TMR_OFS_FLAG     = 5'h10;
  localparam logic [4:0] TMR_OFS_IRQ_EN   = 5'h14;
  localparam logic [4:0] TMR_OFS_IRQ_CLR  = 5'h18;
  // Control register fields.
  localparam int TMR_CTRL_WIDE     = 7;
  localparam int TMR_CTRL_PS_HI    = 5;
  localparam int TMR_CTRL_PS_LO    = 4;
  localparam int TMR_CTRL_CLK_SEL  = 1;
  localparam int TMR_CTRL_ON       = 0;
  // Companion control field and flag/enable field.
  localparam int TMR_COMP_OSC_EN   = 3;
  localparam int TMR_FLAG_OVF      = 1;
  // Reset values.
  localparam logic [7:0]  TMR_CTRL_RST  = 8'h00;
  localparam logic [7:0]  TMR_COMP_RST  = 8'h00;
  localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
  // Auxiliary oscillator half period in main clock cycles, less one.
  localparam logic [7:0]  TMR_OSC_HALF  = 8'h0F;
endpackage

// ==== verilog/tmr_osc.sv ====
// Auxiliary low-frequency oscillator model that yields one-cycle rising-edge enables.
`timescale 1ns/100ps
module tmr_osc
  import tmr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       osc_en,
  input  wire logic [7:0] half_period,
  output logic            osc_rise
);
  logic [7:0] div_reg;
  logic       phase_reg;

  // The oscillator runs only while enabled and stops in a known low phase otherwise.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_reg   <= 8'h00;
      phase_reg <= 1'b0;
      osc_rise  <= 1'b0;
    end else if (!osc_en) begin
      div_reg   <= 8'h00;
      phase_reg <= 1'b0;
      osc_rise  <= 1'b0;
    end else if (div_reg == half_period) begin
      div_reg   <= 8'h00;
      phase_reg <= ~phase_reg;
      osc_rise  <= ~phase_reg;
    end else begin
      div_reg  <= div_reg + 8'h01;
      osc_rise <= 1'b0;
    end
  end

  a_osc_stopped: assert property (@(posedge mclk) disable iff (!resetn)
    !osc_en |=> !osc_rise) else $error("oscillator edge while disabled");
endmodule

// ==== verilog/tmr_top.sv ====
// Sixteen-bit counter with buffered wide access, prescaler, overflow flag and Avalon-MM slave.
// Operation
// - Wide mode maps the high-byte address onto a separate buffer register.
// - Wide mode low-byte read copies live high byte into the buffer.
// - Wide mode low-byte write loads high byte from buffer simultaneously.
// - Wide mode offers no direct path to the live high byte.
// - Only low-byte writes clear the prescaler; high-byte writes leave it.
// - Auxiliary oscillator runs only while its enable bit is set.
// - Clock select set counts rising edges of the auxiliary oscillator.
// - Count pair runs upward 0000h to FFFFh then wraps to 0000h.
// - Overflow sets a latched flag at bit 1 until cleared.
// - Overflow interrupt passes only while enable bit 1 is set.
// - Flag sets regardless of any enable state so software may poll.
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module tmr_top
  import tmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  // Register map, one byte per word-aligned slot, only byte lane zero is used:
  //   0x00 low byte of the count; a write here also restarts the prescaler.
  //   0x04 high byte; in wide mode this slot is the high-byte buffer instead.
  //   0x08 control: bit 7 wide mode, bits 5:4 prescale, bit 1 clock select, bit 0 run.
  //   0x0C companion control: bit 3 enables the auxiliary oscillator.
  //   0x10 flag register: bit 1 is the sticky overflow flag, writing a zero clears it.
  //   0x14 enable register: bit 1 gates the overflow interrupt.
  //   0x18 clear register, write only: a one in bit 1 clears the overflow flag.
  // Unmapped slots read as zero and ignore writes.
  // Software should clear the flag before enabling the interrupt, or a stale
  // overflow raises the interrupt line at once.

  logic [7:0]  timer_control_reg;
  logic [7:0]  companion_timer_control;
  logic [7:0]  count_low_byte;
  logic [7:0]  count_high_byte;
  logic [7:0]  hbuf_reg;
  logic [7:0]  prescale_reg;
  logic [7:0]  ps_mask;
  logic        periph_flag_reg_two;
  logic        periph_enable_reg_two;
  logic        ack_reg;
  logic        osc_rise;
  logic        wide_access_mode;
  logic        count_clock_select;
  logic        tick;
  logic        inc;
  logic        ovf;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_low;
  logic        wr_high;
  logic        rd_low;
  logic        lane0;
  logic [15:0] count_pair;
  logic [15:0] count_next;

  assign wide_access_mode   = timer_control_reg[TMR_CTRL_WIDE];
  assign count_clock_select = timer_control_reg[TMR_CTRL_CLK_SEL];
  assign count_pair         = {count_high_byte, count_low_byte};

  // Every access waits exactly one cycle, so the write and the read side effects fire once.
  // The acknowledge flop is set in the first cycle of a request and cleared in the second,
  // so a master that keeps its strobe high simply starts a fresh access with a new wait cycle.
  // The trade is one cycle of latency per access for a single, well defined taking edge,
  // which matters here because a low-byte read has the side effect of snapping the buffer.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_acc  = avs_write & ack_reg;
  assign rd_acc  = avs_read & ack_reg;
  assign lane0   = avs_byteenable[0];
  assign wr_low  = wr_acc & lane0 & (avs_address == TMR_OFS_LOW);
  assign wr_high = wr_acc & lane0 & (avs_address == TMR_OFS_HIGH);
  assign rd_low  = rd_acc & (avs_address == TMR_OFS_LOW);

  // Auxiliary oscillator, enabled from the companion control register.
  tmr_osc u_osc (
    .mclk        (mclk),
    .resetn      (resetn),
    .osc_en      (companion_timer_control[TMR_COMP_OSC_EN]),
    .half_period (TMR_OSC_HALF),
    .osc_rise    (osc_rise)
  );

  // Source tick: main clock or auxiliary oscillator rising edges.
  assign tick = timer_control_reg[TMR_CTRL_ON] & (count_clock_select ? osc_rise : 1'b1);

  // Prescaler of 1, 2, 4 or 8 picked by a two-bit field.
  // The mask selects how many low prescaler bits must be all ones before a count is let through.
  always_comb begin
    case (timer_control_reg[TMR_CTRL_PS_HI:TMR_CTRL_PS_LO])
      2'b00:   ps_mask = 8'h00;
      2'b01:   ps_mask = 8'h01;
      2'b10:   ps_mask = 8'h03;
      2'b11:   ps_mask = 8'h07;
      default: ps_mask = 8'h00;
    endcase
  end

  assign inc = tick & ((prescale_reg & ps_mask) == ps_mask);

  // The prescaler restarts on low-byte writes only, so a high-byte write cannot disturb phase.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prescale_reg <= 8'h00;
    end else if (wr_low) begin
      prescale_reg <= 8'h00;
    end else if (tick) begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  // Upward count with natural wrap; a write in the same cycle takes precedence over a tick.
  // A low-byte write in the overflow cycle therefore also suppresses the flag, since the
  // written value, not the wrapped one, is what the counter holds afterwards.
  assign count_next = count_pair + 16'h0001;
  assign ovf = inc & (count_pair == 16'hFFFF) & ~wr_low;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_low_byte <= TMR_COUNT_RST[7:0];
    end else if (wr_low) begin
      count_low_byte <= avs_writedata[7:0];
    end else if (inc) begin
      count_low_byte <= count_next[7:0];
    end
  end

  // Live high byte: loaded from the buffer in wide mode, directly in narrow mode.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_high_byte <= TMR_COUNT_RST[15:8];
    end else if (wr_low && wide_access_mode) begin
      count_high_byte <= hbuf_reg;
    end else if (wr_high && !wide_access_mode) begin
      count_high_byte <= avs_writedata[7:0];
    end else if (inc && !wr_low) begin
      count_high_byte <= count_next[15:8];
    end
  end

  // High-byte buffer: written at the high address and snapped on every low-byte read in wide mode.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hbuf_reg <= 8'h00;
    end else if (wr_high && wide_access_mode) begin
      hbuf_reg <= avs_writedata[7:0];
    end else if (rd_low && wide_access_mode) begin
      hbuf_reg <= count_high_byte;
    end
  end

  // Control registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_control_reg       <= TMR_CTRL_RST;
      companion_timer_control <= TMR_COMP_RST;
      periph_enable_reg_two   <= 1'b0;
    end else if (wr_acc && lane0) begin
      if (avs_address == TMR_OFS_CTRL) begin
        timer_control_reg <= avs_writedata[7:0];
      end
      if (avs_address == TMR_OFS_COMP) begin
        companion_timer_control <= avs_writedata[7:0];
      end
      if (avs_address == TMR_OFS_IRQ_EN) begin
        periph_enable_reg_two <= avs_writedata[TMR_FLAG_OVF];
      end
    end
  end

  // Sticky flag: set wins over clear; writing a one to the clear register or a zero to the
  // flag bit clears it, and no hardware path ever clears it otherwise.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periph_flag_reg_two <= 1'b0;
    end else if (ovf) begin
      periph_flag_reg_two <= 1'b1;
    end else if (wr_acc && lane0 && (avs_address == TMR_OFS_IRQ_CLR) && avs_writedata[TMR_FLAG_OVF]) begin
      periph_flag_reg_two <= 1'b0;
    end else if (wr_acc && lane0 && (avs_address == TMR_OFS_FLAG) && !avs_writedata[TMR_FLAG_OVF]) begin
      periph_flag_reg_two <= 1'b0;
    end
  end

  // Level interrupt gated by the enable bit.
  assign irq = periph_flag_reg_two & periph_enable_reg_two;

  // Read mux; in wide mode the high address returns only the buffer.
  always_comb begin
    avs_readdata = 32'h0000_0000;
    case (avs_address)
      TMR_OFS_LOW:    avs_readdata[7:0] = count_low_byte;
      TMR_OFS_HIGH:   avs_readdata[7:0] = wide_access_mode ? hbuf_reg : count_high_byte;
      TMR_OFS_CTRL:   avs_readdata[7:0] = timer_control_reg;
      TMR_OFS_COMP:   avs_readdata[7:0] = companion_timer_control;
      TMR_OFS_FLAG:   avs_readdata[TMR_FLAG_OVF] = periph_flag_reg_two;
      TMR_OFS_IRQ_EN: avs_readdata[TMR_FLAG_OVF] = periph_enable_reg_two;
      default:        avs_readdata = 32'h0000_0000;
    endcase
  end

  a_wrap_zero: assert property (@(posedge mclk) disable iff (!resetn)
    ovf |=> (count_pair == 16'h0000)) else $error("count did not wrap to zero");
  a_flag_sets: assert property (@(posedge mclk) disable iff (!resetn)
    ovf |=> periph_flag_reg_two) else $error("overflow flag not set");
  a_flag_holds: assert property (@(posedge mclk) disable iff (!resetn)
    (periph_flag_reg_two && !wr_acc) |=> periph_flag_reg_two) else $error("flag dropped by hardware");
  a_irq_gate: assert property (@(posedge mclk) disable iff (!resetn)
    irq == (periph_flag_reg_two && periph_enable_reg_two)) else $error("irq gating wrong");
  a_poll_flag: assert property (@(posedge mclk) disable iff (!resetn)
    (ovf && !periph_enable_reg_two) |=> (periph_flag_reg_two && !irq)) else $error("flag not pollable");
  a_snap_high: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_low && wide_access_mode) |=> (hbuf_reg == $past(count_high_byte))) else $error("buffer not snapped");
  a_wide_load: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_low && wide_access_mode) |=> (count_pair == {$past(hbuf_reg), $past(avs_writedata[7:0])}))
    else $error("wide write not atomic");
  a_wide_no_high: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_high && wide_access_mode && !inc) |=> $stable(count_high_byte)) else $error("live high byte written");
  a_narrow_high: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_high && !wide_access_mode) |=> (count_high_byte == $past(avs_writedata[7:0])))
    else $error("narrow high write lost");
  a_ps_clear: assert property (@(posedge mclk) disable iff (!resetn)
    wr_low |=> (prescale_reg == 8'h00)) else $error("prescaler not cleared");
  a_osc_source: assert property (@(posedge mclk) disable iff (!resetn)
    (count_clock_select && !osc_rise) |-> !inc) else $error("count without oscillator edge");


  // A high-byte write alone never disturbs the prescaler phase.
  a_ps_high_keep: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_high && !tick) |=> $stable(prescale_reg)) else $error("prescaler moved on high write");

  // The low byte takes the written value whatever the tick does in that cycle.
  a_low_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_low |=> (count_low_byte == $past(avs_writedata[7:0]))) else $error("low write lost");

  // A clear through the clear register drops the flag unless an overflow lands in the same cycle.
  a_flag_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_acc && lane0 && (avs_address == TMR_OFS_IRQ_CLR) && avs_writedata[TMR_FLAG_OVF] && !ovf)
    |=> !periph_flag_reg_two) else $error("flag not cleared");

  // With the counter stopped and no write, the count pair holds its value.
  a_stop_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (!timer_control_reg[TMR_CTRL_ON] && !wr_acc) |=> $stable(count_pair)) else $error("stopped count moved");

  // Each increment moves the pair up by exactly one, wrapping at the top.
  a_inc_step: assert property (@(posedge mclk) disable iff (!resetn)
    (inc && !wr_acc) |=> (count_pair == 16'($past(count_pair) + 16'h0001))) else $error("count step wrong");

  // Main scenarios; the bench reaches all but c_overflow, since it enables the interrupt only after each overflow.
  c_overflow: cover property (@(posedge mclk) disable iff (!resetn) ovf && periph_enable_reg_two);
  c_wide_read: cover property (@(posedge mclk) disable iff (!resetn) rd_low && wide_access_mode);
  c_wide_write: cover property (@(posedge mclk) disable iff (!resetn) wr_low && wide_access_mode);
  c_osc_count: cover property (@(posedge mclk) disable iff (!resetn) inc && count_clock_select);
  c_flag_clear: cover property (@(posedge mclk) disable iff (!resetn)
    periph_flag_reg_two && wr_acc && (avs_address == TMR_OFS_IRQ_CLR));

  // Limitation: the auxiliary oscillator is a divided model of the main clock, so counts in
  // that mode stay in step with the main clock; a real crystal source would need a
  // synchroniser before the edge detect, and the counter would then lag it by two cycles.
  // Limitation: the run bit gates both clock sources, so a stopped counter ignores oscillator
  // edges as well; software that wants to count only oscillator edges sets both bits.
endmodule

// ==== verif/tmr_tb.sv ====
// Self-checking testbench for the sixteen-bit counter over its Avalon-MM register port.
`timescale 1ns/100ps
module testbench
  import tmr_pkg::*;
;
  logic        mclk;
  logic        resetn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  int          n_fail;
  int          samples_checked;
  logic [31:0] rd;
  logic [7:0]  d;
  logic [7:0]  hi_exp;
  logic [3:0]  be;
  logic [4:0]  ofs [7];
  int          k;

  tmr_top u_dut (
    .mclk            (mclk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq)
  );

  // The clock toggles every 5 ns for a 100 MHz rate.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // A byte only lands when byte lane zero is enabled.
  function automatic logic [7:0] lane_expect(input logic [7:0] old, input logic [7:0] nv, input logic [3:0] e);
    return e[0] ? nv : old;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Waitrequest and read data are taken at the rising edge; the request drops by NBA at that same edge.
  task automatic bus_xfer(input logic [4:0] a, input logic wr, input logic [7:0] wd, input logic [3:0] e,
                          output logic [31:0] q);
    @(posedge mclk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= e;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] wd);
    logic [31:0] q;
    bus_xfer(a, 1'b1, wd, 4'hF, q);
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] q);
    bus_xfer(a, 1'b0, 8'h00, 4'hF, q);
  endtask

  task automatic irq_is(input logic exp);
    @(negedge mclk);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  // A hang counts as a mismatch and ends the run through the common closing task.
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // Main sequence: reset, register map, byte access modes, overflow flag and auxiliary clocking.
  initial begin
    resetn = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h00000000; avs_byteenable = 4'h0; n_fail = 0; samples_checked = 0;
    ofs = '{TMR_OFS_LOW, TMR_OFS_HIGH, TMR_OFS_CTRL, TMR_OFS_COMP, TMR_OFS_FLAG, TMR_OFS_IRQ_EN, 5'h1C};
    void'($urandom(36231));
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    // Every register starts at zero; the unmapped slot reads zero as well.
    foreach (ofs[i]) begin
      bus_rd(ofs[i], rd);
      check(rd, 32'h00000000);
    end
    bus_wr(5'h1C, 8'hFF);
    bus_rd(5'h1C, rd);
    check(rd, 32'h00000000);
    bus_wr(TMR_OFS_IRQ_CLR, 8'h02);
    // Random narrow accesses with random lanes; the stopped counter holds what was written.
    hi_exp = 8'h00;
    for (int i = 0; i < 10; i++) begin
      d = 8'($urandom());
      be = 4'($urandom());
      if (i < 2) be = {3'b111, i[0]};
      bus_xfer(TMR_OFS_HIGH, 1'b1, d, be, rd);
      hi_exp = lane_expect(hi_exp, d, be);
      bus_rd(TMR_OFS_HIGH, rd);
      check(rd, {24'h0, hi_exp});
    end
    // Wide mode: buffer separate from live byte, low read snaps it, low write loads both halves.
    bus_wr(TMR_OFS_HIGH, 8'h55);
    bus_wr(TMR_OFS_CTRL, 8'h80);
    bus_wr(TMR_OFS_HIGH, 8'h99);
    bus_rd(TMR_OFS_HIGH, rd);
    check(rd, 32'h00000099);
    bus_rd(TMR_OFS_LOW, rd);
    bus_rd(TMR_OFS_HIGH, rd);
    check(rd, 32'h00000055);
    bus_wr(TMR_OFS_HIGH, 8'hAB);
    bus_wr(TMR_OFS_LOW, 8'hCD);
    bus_wr(TMR_OFS_HIGH, 8'h11);
    bus_wr(TMR_OFS_CTRL, 8'h00);
    bus_rd(TMR_OFS_HIGH, rd);
    check(rd, 32'h000000AB);
    bus_rd(TMR_OFS_LOW, rd);
    check(rd, 32'h000000CD);
    // Overflow twice, once cleared through the clear register and once by writing zero to the flag.
    for (int m = 0; m < 2; m++) begin
      bus_wr(TMR_OFS_HIGH, 8'hFF);
      bus_wr(TMR_OFS_LOW, 8'hF0);
      bus_wr(TMR_OFS_CTRL, 8'h01);
      k = 0;
      do begin
        bus_rd(TMR_OFS_FLAG, rd);
        k++;
      end while (rd[1] !== 1'b1 && k < 40);
      bus_wr(TMR_OFS_CTRL, 8'h00);
      check(rd, 32'h00000002);
      irq_is(1'b0);
      bus_rd(TMR_OFS_HIGH, rd);
      check(rd, 32'h00000000);
      bus_wr(TMR_OFS_IRQ_EN, 8'h02);
      irq_is(1'b1);
      repeat (20) @(posedge mclk);
      bus_rd(TMR_OFS_FLAG, rd);
      check(rd, 32'h00000002);
      if (m == 0) bus_wr(TMR_OFS_IRQ_CLR, 8'h02);
      else bus_wr(TMR_OFS_FLAG, 8'h00);
      bus_rd(TMR_OFS_FLAG, rd);
      check(rd, 32'h00000000);
      irq_is(1'b0);
      bus_wr(TMR_OFS_IRQ_EN, 8'h00);
    end
    // Auxiliary clock: no counting while its oscillator is off, about one count per 32 cycles when on.
    bus_wr(TMR_OFS_HIGH, 8'h00);
    bus_wr(TMR_OFS_LOW, 8'h00);
    bus_wr(TMR_OFS_CTRL, 8'h03);
    repeat (100) @(posedge mclk);
    bus_rd(TMR_OFS_LOW, rd);
    check(rd, 32'h00000000);
    bus_wr(TMR_OFS_COMP, 8'h08);
    repeat (200) @(posedge mclk);
    bus_wr(TMR_OFS_CTRL, 8'h00);
    bus_rd(TMR_OFS_LOW, rd);
    check({31'h0, rd >= 32'd5 && rd <= 32'd9}, 32'h00000001);
    end_of_test();
  end
endmodule
